//--- core/fsp_defs.svh
// Constants for the flash sector protection block
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// Lock register bit positions
`define FSP_LOCK_REGION_BIT     0
`define FSP_LOCK_PERSIST_BIT    1
`define FSP_LOCK_PASSWORD_BIT   2
`define FSP_LOCK_OTP_BIT        3
`define FSP_LOCK_WIDTH          4
`define FSP_LOCK_READ_WIDTH     16
`define FSP_LOCK_RESERVED       12'hfff
// Password check delay
`define FSP_CLK_PERIOD_NS       20
`define FSP_PW_DELAY_NS         1000
`define FSP_PW_DELAY_CYC        ((`FSP_PW_DELAY_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`define FSP_PW_WIDTH            64
`endif

//--- core/fsp_pkg.sv
// Types for the flash sector protection block
`default_nettype none
package fsp_pkg;
  typedef enum logic [3:0] {
    FSP_CMD_NONE,
    FSP_CMD_DYN_SET,
    FSP_CMD_DYN_CLR,
    FSP_CMD_PERS_PROG,
    FSP_CMD_PERS_ERASE_ALL,
    FSP_CMD_FREEZE_SET,
    FSP_CMD_PW_UNLOCK,
    FSP_CMD_PW_PROG,
    FSP_CMD_PW_VERIFY,
    FSP_CMD_LOCK_PROG,
    FSP_CMD_LOCK_READ,
    FSP_CMD_DYN_STATUS,
    FSP_CMD_PERS_STATUS,
    FSP_CMD_FREEZE_STATUS,
    FSP_CMD_ARRAY_WRITE
  } fsp_cmd_t;

  typedef enum logic [1:0] {
    FSP_ST_READ,
    FSP_ST_PW_WAIT,
    FSP_ST_POLL
  } fsp_state_t;
endpackage
`default_nettype wire

//--- core/fsp_pw_if.sv
// Handshake between the protection core and the password checker
`timescale 1ns/1ps
`default_nettype none
interface fsp_pw_if;
  logic        start;
  logic [63:0] guess;
  logic [63:0] stored;
  logic        done;
  logic        match;
  modport core (output start, output guess, output stored, input done, input match);
  modport chk  (input start, input guess, input stored, output done, output match);
endinterface
`default_nettype wire

//--- core/fsp_pw_check.sv
// Password comparator with a fixed delay before its answer
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
module fsp_pw_check
  import fsp_pkg::*;
#(
  parameter int DELAY_CYC = `FSP_PW_DELAY_CYC
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  fsp_pw_if.chk     pw
);
  typedef struct packed {
    logic        busy;
    logic [15:0] cnt;
    logic        hit;
    logic        done;
  } fsp_chk_t;

  fsp_chk_t s_q;
  fsp_chk_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && pw.start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = 16'h0000;
      s_d.hit  = (pw.guess == pw.stored);
    end else if (s_q.busy) begin
      if (s_q.cnt == 16'(DELAY_CYC - 1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pw.done  = s_q.done;
  assign pw.match = s_q.hit;
endmodule
`default_nettype wire

//--- core/fsp_core.sv
// Sector protection core: protect bits, freeze bit, lock register, pins
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
// Summary of operation
// - One volatile dynamic protect bit per sector, changeable any number of times.
// - Dynamic set writes 0 (protected); clear writes 1.
// - Sector protected if dynamic or persistent bit is 0; freeze irrelevant.
// - Persistent mode: freeze comes up 1; persistent bits keep values.
// - Dynamic bits load the build option at reset; default all cleared.
// - Persistent bits frozen while freeze bit is 0.
// - Program or erase to protected sector: brief polling, no change, back to read.
// - Status reads return dynamic bit, persistent bit and freeze bit.
// - Password mode forces freeze to locked at reset.
// - Password unlock with 64-bit value clears freeze on match only.
// - Each password compare waits a fixed 1 us.
// - Password mode lock makes password unreadable and unprogrammable.
// - Password unlock ignored in persistent mode.
// - Freeze initialised from password mode lock; only unlock clears it there.
// - Lock register: region protect, persistent lock, password lock, OTP bit.
// - Reserved upper lock register bits read as ones.
// - Write-protect pin low refuses program and erase on outermost boot sectors.
// - Program boost pin low locks every sector.
// - Protect bits act the same at boost high-voltage or logic high.
// - Dedicated command sets freeze to 0; only reset in persistent mode or password unlock clears it.
// - Persistent bits programmed singly, erased all at once, blocked when frozen.
// - Both mode locks at once abort; each mode lock blocks the other.
module fsp_core
  import fsp_pkg::*;
#(
  parameter int          SECTORS   = 16,
  parameter int          SEC_W     = 4,
  parameter int          BOOT_LO   = 2,
  parameter int          BOOT_HI   = 2,
  parameter bit          DYN_INIT  = 1'b1,
  parameter int          POLL_CYC  = 4,
  parameter int          PW_DELAY  = `FSP_PW_DELAY_CYC
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_cmd_valid,
  input  wire fsp_cmd_t           i_cmd,
  input  wire logic [SEC_W-1:0]   i_sector,
  input  wire logic [63:0]        i_data,
  input  wire logic               i_wp_n,
  input  wire logic               i_boost_n,
  input  wire logic [SECTORS-1:0] i_pers_nv,
  input  wire logic [3:0]         i_lock_nv,
  input  wire logic [63:0]        i_pw_nv,
  output logic                    o_busy,
  output logic                    o_poll,
  output logic                    o_array_go,
  output logic                    o_array_refused,
  output logic                    o_rd_valid,
  output logic [63:0]             o_rd_data,
  output logic                    o_lock_abort,
  output logic [SECTORS-1:0]      o_pers_bits,
  output logic [3:0]              o_lock_bits,
  output logic [63:0]             o_pw_bits
);
  typedef struct packed {
    fsp_state_t            st;
    logic                  busy;
    logic [SECTORS-1:0]    dyn;
    logic [SECTORS-1:0]    pers;
    logic                  freeze;
    logic [3:0]            lock;
    logic [63:0]           pw;
    logic                  loaded;
    logic [7:0]            cnt;
    logic                  poll;
    logic                  go;
    logic                  refused;
    logic                  rd_valid;
    logic [63:0]           rd_data;
    logic                  abort;
    logic                  pw_start;
    logic [63:0]           guess;
  } fsp_core_state_t;

  fsp_core_state_t s_q;
  fsp_core_state_t s_d;

  fsp_pw_if pw_bus ();

  fsp_pw_check #(
    .DELAY_CYC (PW_DELAY)
  ) u_pw_check (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .pw         (pw_bus.chk)
  );

  assign pw_bus.start  = s_q.pw_start;
  assign pw_bus.guess  = s_q.guess;
  assign pw_bus.stored = s_q.pw;

  logic [SECTORS-1:0] boot_mask;
  logic               sec_prot;
  logic               pw_mode;
  logic               pw_locked;
  logic [3:0]         lock_req;

  // ----------------------------------------------------------------
  // Boot sector map
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SECTORS; g++) begin : g_boot
      assign boot_mask[g] = (g < BOOT_LO) || (g >= SECTORS - BOOT_HI);
    end
  endgenerate

  always_comb begin
    pw_mode   = ~s_q.lock[`FSP_LOCK_PASSWORD_BIT];
    pw_locked = pw_mode;
    lock_req  = i_data[3:0];
    // boost level beyond logic high has no effect
    sec_prot  = ~(s_q.dyn[i_sector] & s_q.pers[i_sector]);
    if (!i_wp_n && boot_mask[i_sector]) begin
      sec_prot = 1'b1;
    end
    if (!i_boost_n) begin
      sec_prot = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command handling
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.go       = 1'b0;
    s_d.refused  = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.abort    = 1'b0;
    s_d.pw_start = 1'b0;
    if (!s_q.loaded) begin
      // Non-volatile copies are caught after reset release, not under reset
      s_d.loaded = 1'b1;
      // persistent bits keep their stored values
      s_d.pers   = i_pers_nv;
      s_d.lock   = i_lock_nv;
      s_d.pw     = i_pw_nv;
      s_d.freeze = i_lock_nv[`FSP_LOCK_PASSWORD_BIT];
    end else begin
      unique case (s_q.st)
        FSP_ST_READ: begin
          if (i_cmd_valid) begin
            unique case (i_cmd)
              FSP_CMD_DYN_SET: begin
                s_d.dyn[i_sector] = 1'b0;
              end
              FSP_CMD_DYN_CLR: begin
                s_d.dyn[i_sector] = 1'b1;
              end
              FSP_CMD_PERS_PROG: begin
                if (s_q.freeze) begin
                  s_d.pers[i_sector] = 1'b0;
                end
              end
              FSP_CMD_PERS_ERASE_ALL: begin
                if (s_q.freeze) begin
                  s_d.pers = '1;
                end
              end
              FSP_CMD_FREEZE_SET: begin
                s_d.freeze = 1'b0;
              end
              FSP_CMD_PW_UNLOCK: begin
                if (pw_mode) begin
                  s_d.pw_start = 1'b1;
                  s_d.guess    = i_data;
                  s_d.st       = FSP_ST_PW_WAIT;
                end
              end
              FSP_CMD_PW_PROG: begin
                if (!pw_locked) begin
                  s_d.pw = s_q.pw & i_data;
                end
              end
              FSP_CMD_PW_VERIFY: begin
                s_d.rd_valid = 1'b1;
                s_d.rd_data  = pw_locked ? 64'h0000000000000000 : s_q.pw;
              end
              FSP_CMD_LOCK_PROG: begin
                // both together, or crossing modes, abort
                if ((!lock_req[`FSP_LOCK_PERSIST_BIT] && !lock_req[`FSP_LOCK_PASSWORD_BIT])
                    || (!lock_req[`FSP_LOCK_PASSWORD_BIT] && !s_q.lock[`FSP_LOCK_PERSIST_BIT])
                    || (!lock_req[`FSP_LOCK_PERSIST_BIT] && !s_q.lock[`FSP_LOCK_PASSWORD_BIT])) begin
                  s_d.abort = 1'b1;
                end else begin
                  // one-time bits only go to 0
                  s_d.lock = s_q.lock & lock_req;
                end
              end
              FSP_CMD_LOCK_READ: begin
                s_d.rd_valid = 1'b1;
                s_d.rd_data  = {48'h000000000000, `FSP_LOCK_RESERVED, s_q.lock};
              end
              FSP_CMD_DYN_STATUS: begin
                s_d.rd_valid = 1'b1;
                s_d.rd_data  = {63'h0, s_q.dyn[i_sector]};
              end
              FSP_CMD_PERS_STATUS: begin
                s_d.rd_valid = 1'b1;
                s_d.rd_data  = {63'h0, s_q.pers[i_sector]};
              end
              FSP_CMD_FREEZE_STATUS: begin
                s_d.rd_valid = 1'b1;
                s_d.rd_data  = {63'h0, s_q.freeze};
              end
              FSP_CMD_ARRAY_WRITE: begin
                if (sec_prot) begin
                  s_d.refused = 1'b1;
                  s_d.poll    = 1'b1;
                  s_d.cnt     = 8'h00;
                  s_d.st      = FSP_ST_POLL;
                end else begin
                  s_d.go = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
        FSP_ST_PW_WAIT: begin
          if (pw_bus.done) begin
            // clear on match, nothing on mismatch
            if (pw_bus.match) begin
              s_d.freeze = 1'b1;
            end
            s_d.st = FSP_ST_READ;
          end
        end
        FSP_ST_POLL: begin
          if (s_q.cnt == 8'(POLL_CYC - 1)) begin
            s_d.poll = 1'b0;
            s_d.st   = FSP_ST_READ;
          end else begin
            s_d.cnt = s_q.cnt + 8'h01;
          end
        end
      endcase
    end
    // Busy is registered so the port comes straight from a flop
    s_d.busy = (s_d.st != FSP_ST_READ) || !s_d.loaded;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q        <= '0;
      s_q.busy   <= 1'b1;
      s_q.dyn    <= {SECTORS{DYN_INIT}};
      s_q.pers   <= '1;
      s_q.lock   <= 4'hf;
      s_q.pw     <= '1;
      s_q.freeze <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_busy          = s_q.busy;
  assign o_poll          = s_q.poll;
  assign o_array_go      = s_q.go;
  assign o_array_refused = s_q.refused;
  assign o_rd_valid      = s_q.rd_valid;
  assign o_rd_data       = s_q.rd_data;
  assign o_lock_abort    = s_q.abort;
  assign o_pers_bits     = s_q.pers;
  assign o_lock_bits     = s_q.lock;
  assign o_pw_bits       = s_q.pw;
endmodule
`default_nettype wire

//--- tb/fsp_core_chk.sv
// Port checks for the sector protection core
`timescale 1ns/1ps
`default_nettype none
module fsp_core_chk
  import fsp_pkg::*;
#(
  parameter int SECTORS = 16,
  parameter int SEC_W   = 4,
  parameter int BOOT_LO = 2,
  parameter int BOOT_HI = 2
) (
  input wire logic               i_core_clk,
  input wire logic               i_rst_n,
  input wire logic               i_cmd_valid,
  input wire fsp_cmd_t           i_cmd,
  input wire logic [SEC_W-1:0]   i_sector,
  input wire logic [63:0]        i_data,
  input wire logic               i_wp_n,
  input wire logic               i_boost_n,
  input wire logic               o_busy,
  input wire logic               o_poll,
  input wire logic               o_array_go,
  input wire logic               o_array_refused,
  input wire logic               o_rd_valid,
  input wire logic [63:0]        o_rd_data,
  input wire logic               o_lock_abort,
  input wire logic [SECTORS-1:0] o_pers_bits,
  input wire logic [3:0]         o_lock_bits
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic take;
  assign take = i_cmd_valid && !o_busy;
  sequence s_write;
    take && i_cmd == FSP_CMD_ARRAY_WRITE;
  endsequence
  sequence s_poll;
    o_poll [*4] ##1 !o_poll;
  endsequence
  AST_STATUS_ANSWER: assert property (
    take && i_cmd inside {FSP_CMD_DYN_STATUS, FSP_CMD_PERS_STATUS, FSP_CMD_FREEZE_STATUS}
    |=> o_rd_valid) else $error("status read not answered");
  AST_LOCK_READ: assert property (
    take && i_cmd == FSP_CMD_LOCK_READ |=> o_rd_data == {48'h0, 12'hfff, $past(o_lock_bits)})
    else $error("lock read value wrong");
  AST_BOOST_LOCK: assert property (
    s_write ##0 !i_boost_n |=> o_array_refused && !o_array_go)
    else $error("write passed with boost pin low");
  AST_WP_BOOT: assert property (
    s_write ##0 (!i_wp_n && (i_sector < BOOT_LO || i_sector >= SECTORS - BOOT_HI))
    |=> o_array_refused) else $error("boot sector write passed with wp low");
  AST_REFUSE_POLL: assert property (
    o_array_refused |-> s_poll) else $error("poll length wrong after refusal");
  AST_GO_ON_TAKE: assert property (
    o_array_go |-> $past(take && i_cmd == FSP_CMD_ARRAY_WRITE)) else $error("go without write");
  AST_PERS_SINGLE: assert property (
    take && i_cmd == FSP_CMD_PERS_PROG |-> ##2
    ((o_pers_bits ^ $past(o_pers_bits, 2)) & ~(SECTORS'(1) << $past(i_sector, 2))) == '0)
    else $error("persistent program touched another sector");
  AST_UNLOCK_WAIT: assert property (
    take && i_cmd == FSP_CMD_PW_UNLOCK && !o_lock_bits[2] |=> o_busy [*3])
    else $error("password compare too fast");
  AST_BOTH_ABORT: assert property (
    take && i_cmd == FSP_CMD_LOCK_PROG && i_data[2:1] == 2'b00 |=> o_lock_abort && $stable(o_lock_bits))
    else $error("double mode lock not aborted");
  AST_PW_HIDDEN: assert property (
    take && i_cmd == FSP_CMD_PW_VERIFY && !o_lock_bits[2] |=> o_rd_data == 64'h0)
    else $error("password readable after lock");
endmodule
bind fsp_core fsp_core_chk #(
  .SECTORS(SECTORS), .SEC_W(SEC_W), .BOOT_LO(BOOT_LO), .BOOT_HI(BOOT_HI)
) i_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .i_sector(i_sector), .i_data(i_data), .i_wp_n(i_wp_n), .i_boost_n(i_boost_n),
  .o_busy(o_busy), .o_poll(o_poll), .o_array_go(o_array_go),
  .o_array_refused(o_array_refused), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
  .o_lock_abort(o_lock_abort), .o_pers_bits(o_pers_bits), .o_lock_bits(o_lock_bits)
);
`default_nettype wire

//--- tb/fsp_host.sv
// Host model: issues one protection command at a time
`timescale 1ns/1ps
`default_nettype none
module fsp_host
  import fsp_pkg::*;
(
  input  wire logic  i_core_clk,
  input  wire logic  i_busy,
  output logic       o_valid,
  output fsp_cmd_t   o_cmd,
  output logic [3:0] o_sector,
  output logic [63:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_cmd = FSP_CMD_NONE;
    o_sector = 4'h0;
    o_data = 64'h0;
  end
  task automatic send(input fsp_cmd_t c, input logic [3:0] s, input logic [63:0] d);
    int n;
    n = 0;
    @(negedge i_core_clk);
    while (i_busy !== 1'b0 && n < 500) begin
      @(negedge i_core_clk);
      n++;
    end
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_cmd <= c;
    o_sector <= s;
    o_data <= d;
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    // Released lines must not keep looking valid
    o_sector <= ~s;
    o_data <= ~d;
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Testbench for the sector protection core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fsp_pkg::*;
  localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
  logic clk, rst_n, valid, wp_n, boost_n, busy, poll, go, refused, rd_valid, abort;
  fsp_cmd_t    cmd;
  logic [3:0]  sector, lock_nv, lock_bits;
  logic [63:0] data, rd_data, pw_nv, pw_bits;
  logic [15:0] pers_nv, pers_bits;
  int          miscompares, checked;
  fsp_core #(.SECTORS(16), .BOOT_LO(2), .BOOT_HI(2), .POLL_CYC(4), .PW_DELAY(3)) i_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(valid), .i_cmd(cmd),
    .i_sector(sector), .i_data(data), .i_wp_n(wp_n), .i_boost_n(boost_n),
    .i_pers_nv(pers_nv), .i_lock_nv(lock_nv), .i_pw_nv(pw_nv), .o_busy(busy),
    .o_poll(poll), .o_array_go(go), .o_array_refused(refused), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_lock_abort(abort), .o_pers_bits(pers_bits),
    .o_lock_bits(lock_bits), .o_pw_bits(pw_bits));
  fsp_host i_host (.i_core_clk(clk), .i_busy(busy), .o_valid(valid), .o_cmd(cmd),
    .o_sector(sector), .o_data(data));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input fsp_cmd_t c, input logic [3:0] s, input logic [63:0] exp,
                    input string what);
    i_host.send(c, s, 64'h0);
    @(negedge clk);
    chk("rd_valid", rd_valid, 1'b1);
    chk(what, rd_data, exp);
  endtask
  task automatic wr(input logic [3:0] s, input logic exp_go);
    i_host.send(FSP_CMD_ARRAY_WRITE, s, 64'h0);
    @(negedge clk);
    chk("go", go, exp_go);
    chk("refused", refused, !exp_go);
    chk("poll", poll, !exp_go);
    chk("busy", busy, !exp_go);
  endtask
  task automatic do_cmd(input fsp_cmd_t c, input logic [3:0] s, input logic [63:0] d);
    i_host.send(c, s, d);
    repeat (2) @(negedge clk);
  endtask
  task automatic reset_dut(input logic [3:0] lk);
    @(posedge clk);
    rst_n <= 1'b0;
    lock_nv <= lk;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    boost_n = 1'b1;
    pers_nv = 16'hfffe;
    lock_nv = 4'hf;
    pw_nv = PW;
    miscompares = 0;
    checked = 0;
    reset_dut(4'hf);
    rd(FSP_CMD_FREEZE_STATUS, 4'h0, 64'h1, "freeze");
    rd(FSP_CMD_DYN_STATUS, 4'h5, 64'h1, "dyn5");
    rd(FSP_CMD_PERS_STATUS, 4'h0, 64'h0, "pers0");
    rd(FSP_CMD_LOCK_READ, 4'h0, {48'h0, 12'hfff, 4'hf}, "lock");
    do_cmd(FSP_CMD_PW_PROG, 4'h0, 64'hffff_ffff_ffff_ff00);
    chk("pw prog", pw_bits, 64'h0123_4567_89ab_cd00);
    rd(FSP_CMD_PW_VERIFY, 4'h0, 64'h0123_4567_89ab_cd00, "pw open");
    do_cmd(FSP_CMD_LOCK_PROG, 4'h0, 64'he);
    rd(FSP_CMD_LOCK_READ, 4'h0, {48'h0, 12'hfff, 4'he}, "lock prog");
    wr(4'h5, 1'b1);
    wr(4'h0, 1'b0);
    do_cmd(FSP_CMD_DYN_SET, 4'h5, 64'h0);
    wr(4'h5, 1'b0);
    rd(FSP_CMD_DYN_STATUS, 4'h5, 64'h0, "dyn5 set");
    do_cmd(FSP_CMD_DYN_CLR, 4'h5, 64'h0);
    wr(4'h5, 1'b1);
    @(posedge clk);
    wp_n <= 1'b0;
    for (int s = 0; s < 16; s++) wr(s[3:0], s >= 2 && s <= 13);
    @(posedge clk);
    wp_n <= 1'b1;
    boost_n <= 1'b0;
    wr(4'h5, 1'b0);
    @(posedge clk);
    boost_n <= 1'b1;
    do_cmd(FSP_CMD_PERS_ERASE_ALL, 4'h0, 64'h0);
    chk("pers erased", pers_bits, 16'hffff);
    do_cmd(FSP_CMD_PERS_PROG, 4'h6, 64'h0);
    chk("pers prog", pers_bits, 16'hffbf);
    wr(4'h6, 1'b0);
    // Boot code freezes early with wp held low
    @(posedge clk);
    wp_n <= 1'b0;
    do_cmd(FSP_CMD_FREEZE_SET, 4'h0, 64'h0);
    wr(4'hf, 1'b0);
    rd(FSP_CMD_FREEZE_STATUS, 4'h0, 64'h0, "frozen");
    do_cmd(FSP_CMD_PERS_ERASE_ALL, 4'h0, 64'h0);
    do_cmd(FSP_CMD_PERS_PROG, 4'h3, 64'h0);
    chk("pers frozen", pers_bits, 16'hffbf);
    do_cmd(FSP_CMD_PW_UNLOCK, 4'h0, PW);
    rd(FSP_CMD_FREEZE_STATUS, 4'h0, 64'h0, "unlock ignored");
    i_host.send(FSP_CMD_LOCK_PROG, 4'h0, 64'h9);
    @(negedge clk);
    chk("abort both", abort, 1'b1);
    chk("lock kept", lock_bits, 4'he);
    reset_dut(4'hb);
    rd(FSP_CMD_FREEZE_STATUS, 4'h0, 64'h0, "pw freeze");
    rd(FSP_CMD_PW_VERIFY, 4'h0, 64'h0, "pw hidden");
    do_cmd(FSP_CMD_PW_UNLOCK, 4'h0, PW ^ 64'h1);
    rd(FSP_CMD_FREEZE_STATUS, 4'h0, 64'h0, "bad pw");
    i_host.send(FSP_CMD_PW_UNLOCK, 4'h0, PW);
    // Compare holds the core busy for PW_DELAY plus two cycles
    repeat (5) @(negedge clk);
    chk("pw wait", busy, 1'b1);
    @(negedge clk);
    chk("pw done", busy, 1'b0);
    rd(FSP_CMD_FREEZE_STATUS, 4'h0, 64'h1, "good pw");
    i_host.send(FSP_CMD_LOCK_PROG, 4'h0, 64'hd);
    @(negedge clk);
    chk("abort other", abort, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
